// *** hdl/umcs_consts.svh ***
/*
  Offsets, field positions, reset values and timing counts of the modem
  control and status block. Assumes inclusion by bare name from hdl/.
*/
`ifndef UMCS_CONSTS_SVH
`define UMCS_CONSTS_SVH

// ==========================================================
// register addresses on the 3-bit host address
`define UMCS_ADDR_W 3
`define UMCS_MODEM_CONTROL_ADDR 3'h4
`define UMCS_MODEM_STATUS_ADDR 3'h6

// ==========================================================
// modem control register fields
`define UMCS_MC_CLK_DIV4 7
`define UMCS_MC_TCR_TLR_EN 6
`define UMCS_MC_XON_ANY 5
`define UMCS_MC_LOOPBACK 4
`define UMCS_MC_GP_OUT 3
`define UMCS_MC_FIFO_RDY 2
`define UMCS_MC_RTS 1
`define UMCS_MC_DTR 0

// ==========================================================
// modem status register fields
`define UMCS_MS_CD 7
`define UMCS_MS_RI 6
`define UMCS_MS_DSR 5
`define UMCS_MS_CTS 4
`define UMCS_MS_DELTA_CD 3
`define UMCS_MS_TRAIL_RI 2
`define UMCS_MS_DELTA_DSR 1
`define UMCS_MS_DELTA_CTS 0

// ==========================================================
// reset values and timing counts
`define UMCS_MODEM_CONTROL_RST 8'h00
`define UMCS_RDATA_RST 8'h00
`define UMCS_PRESCALE_DIV 3'h4
`define UMCS_PRESCALE_LAST 2'h3

`endif

// *** hdl/umcs_pkg.sv ***
/*
  Types shared by the modem control and status block.
  Assumes umcs_consts.svh for the numeric values.
*/
package umcs_pkg;

  // ==========================================================
  // prescaler selection
  typedef enum logic [1:0] {
    UMCS_DIV1 = 2'b01,
    UMCS_DIV4 = 2'b10
  } umcs_div_t;

  // ==========================================================
  // state of the top module
  typedef struct packed {
    logic [7:0] modem_control_reg;
    logic [3:0] delta;
    logic [7:0] rdata;
    logic [1:0] pre_cnt;
    logic clk_en;
    logic rts_n;
    logic dtr_n;
    logic gp_out_n;
    logic tx_pin;
    logic rx_core;
  } umcs_top_st_t;

endpackage

// *** hdl/umcs_sync.sv ***
/*
  Two-stage synchroniser for a vector of levels.
  Assumes asynchronous active-low reset; the first stage feeds only the second.
*/
`timescale 1ns/100ps
module umcs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } umcs_sync_st_t;

  umcs_sync_st_t st_q;
  umcs_sync_st_t st_d;

  initial begin
    if (WIDTH < 1) $error("umcs_sync width must be at least one");
  end

  // ==========================================================
  // two flops in series
  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= {RESET_VAL, RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// *** hdl/umcs_edge.sv ***
/*
  Change and rising-edge detector over synchronised levels.
  Assumes inputs already on clk; first cycle after reset reports nothing.
*/
`timescale 1ns/100ps
module umcs_edge #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] lvl,
  output logic [WIDTH-1:0] toggle,
  output logic [WIDTH-1:0] rise
);
  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic vld;
  } umcs_edge_st_t;

  umcs_edge_st_t st_q;
  umcs_edge_st_t st_d;

  initial begin
    if (WIDTH < 1) $error("umcs_edge width must be at least one");
  end

  // ==========================================================
  // remember last level
  always_comb begin
    st_d = st_q;
    st_d.prev = lvl;
    st_d.vld = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign toggle = st_q.vld ? (lvl ^ st_q.prev) : '0;
  assign rise = st_q.vld ? (lvl & ~st_q.prev) : '0;
endmodule

// *** hdl/umcs_top.sv ***
/*
  Modem control and status logic of one UART channel: control register,
  status register with change flags, loop-back routing and input prescale.
  Assumes a same-clock 8-bit host port with one-cycle strobes, modem pins
  that are asynchronous, and a UART core that supplies tx and consumes rx.
*/
`timescale 1ns/100ps
`include "umcs_consts.svh"

// Summary of operation
// R1 - control bit 7 picks undivided or divide-by-four clock for baud generation
// R2 - control bit 6 opens access to transmission control and trigger registers
// R3 - control bit 5 lets any received character resume halted transmission
// R4 - control bits 7 to 5 change only while enhanced write enable is set
// R5 - control bit 4 enters loop-back, transmit routed internally to receive
// R6 - in loop-back control bits 3,2,1,0 feed status bits 7,6,4,5
// R7 - control bit 3 drives general output low when set, high when clear; held high in loop-back
// R8 - control bit 2 enables the combined FIFO-ready status register
// R9 - control bit 1 drives request-to-send low when set, unless automatic mode; held high in loop-back
// R10 - control bit 0 drives data-terminal-ready low when set, high when clear; held high in loop-back
// R11 - outside loop-back status bits 7 to 4 are complemented modem input pins
// R12 - status bit 3 sets on any carrier change, clears on status read
// R13 - status bit 2 sets on ring low-to-high only, clears on status read
// R14 - status bit 1 sets on data-set-ready change, clears on status read
// R15 - status bit 0 sets on clear-to-send change, clears on status read
// R16 - modem inputs are active low; status presents them active high
// R17 - with interrupt enable bit 3 set, pending changes raise modem interrupt
// R18 - modem inputs are synchronised before change detection, one flag per edge
module umcs_top
  import umcs_pkg::*;
#(
  parameter int PRESCALE = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_cs,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [`UMCS_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic enh_write_en,
  input wire logic auto_rts_en,
  input wire logic auto_rts_n,
  input wire logic modem_irq_en,
  input wire logic core_tx,
  output logic core_rx,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic cd_n,
  input wire logic ri_n,
  input wire logic dsr_n,
  input wire logic cts_n,
  output logic rts_n,
  output logic dtr_n,
  output logic gp_out_n,
  output logic baud_clk_en,
  output logic tcr_tlr_access,
  output logic xon_any_en,
  output logic fifo_rdy_en,
  output logic loopback_en,
  output logic modem_irq
);

  // ==========================================================
  // elaboration checks
  initial begin
    if (PRESCALE != 4) $error("umcs_top only supports a prescale of four");
  end

  // ==========================================================
  // helpers
  function automatic logic reg_hit(
    input logic cs,
    input logic strobe,
    input logic [`UMCS_ADDR_W-1:0] addr,
    input logic [`UMCS_ADDR_W-1:0] target
  );
    reg_hit = cs & strobe & (addr == target);
  endfunction

  function automatic umcs_div_t div_sel(input logic div4);
    div_sel = div4 ? UMCS_DIV4 : UMCS_DIV1;
  endfunction

  // ==========================================================
  // reset release
  logic rst_sync_n;

  umcs_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_rst_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(rst_sync_n)
  );

  // ==========================================================
  // pin synchronisers
  logic [4:0] pins_sync;
  logic cd_n_s;
  logic ri_n_s;
  logic dsr_n_s;
  logic cts_n_s;
  logic rx_pin_s;

  umcs_sync #(
    .WIDTH(5),
    .RESET_VAL(5'h1f)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d({cd_n, ri_n, dsr_n, cts_n, rx_pin}),
    .q(pins_sync)
  ); // R18

  assign cd_n_s = pins_sync[4];
  assign ri_n_s = pins_sync[3];
  assign dsr_n_s = pins_sync[2];
  assign cts_n_s = pins_sync[1];
  assign rx_pin_s = pins_sync[0];

  // ==========================================================
  // state
  umcs_top_st_t st_q;
  umcs_top_st_t st_d;

  logic loop;
  logic [3:0] status_lvl;
  logic [3:0] edge_src;
  logic [3:0] edge_tog;
  logic [3:0] edge_rise;
  logic [3:0] delta_set;
  logic [7:0] status_word;
  logic wr_control;
  logic rd_control;
  logic rd_status;
  umcs_div_t div_mode;

  assign loop = st_q.modem_control_reg[`UMCS_MC_LOOPBACK]; // R5
  assign div_mode = div_sel(st_q.modem_control_reg[`UMCS_MC_CLK_DIV4]);

  // ==========================================================
  // status levels, bit order cd, ri, dsr, cts
  always_comb begin
    if (loop) begin
      status_lvl = {st_q.modem_control_reg[`UMCS_MC_GP_OUT], st_q.modem_control_reg[`UMCS_MC_FIFO_RDY],
                    st_q.modem_control_reg[`UMCS_MC_DTR], st_q.modem_control_reg[`UMCS_MC_RTS]}; // R6
      edge_src = status_lvl;
    end else begin
      status_lvl = ~{cd_n_s, ri_n_s, dsr_n_s, cts_n_s}; // R11 R16
      edge_src = {cd_n_s, ri_n_s, dsr_n_s, cts_n_s};
    end
  end

  umcs_edge #(
    .WIDTH(4)
  ) u_edge (
    .clk(clk),
    .rst_n(rst_sync_n),
    .lvl(edge_src),
    .toggle(edge_tog),
    .rise(edge_rise)
  );

  // ==========================================================
  // change flags
  assign delta_set = {edge_tog[3], // R12
                      edge_rise[2], // R13
                      edge_tog[1], // R14
                      edge_tog[0]}; // R15

  assign status_word = {status_lvl, st_q.delta};

  // ==========================================================
  // host decode
  assign wr_control = reg_hit(bus_cs, bus_wr, bus_addr, `UMCS_MODEM_CONTROL_ADDR);
  assign rd_control = reg_hit(bus_cs, bus_rd, bus_addr, `UMCS_MODEM_CONTROL_ADDR);
  assign rd_status = reg_hit(bus_cs, bus_rd, bus_addr, `UMCS_MODEM_STATUS_ADDR);

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;

    // control register write
    if (wr_control) begin
      st_d.modem_control_reg[4:0] = bus_wdata[4:0];
      if (enh_write_en) begin
        st_d.modem_control_reg[7:5] = bus_wdata[7:5]; // R4
      end
    end

    // read data
    if (rd_control) begin
      st_d.rdata = st_q.modem_control_reg;
    end else if (rd_status) begin
      st_d.rdata = status_word;
    end else if (bus_cs & bus_rd) begin
      st_d.rdata = `UMCS_RDATA_RST;
    end

    // change flags: read clears, a new change wins
    if (rd_status) begin
      st_d.delta = delta_set; // R12 R13 R14 R15
    end else begin
      st_d.delta = st_q.delta | delta_set;
    end

    // input clock prescale
    case (div_mode)
      UMCS_DIV1: begin
        st_d.pre_cnt = 2'h0;
        st_d.clk_en = 1'b1; // R1
      end
      UMCS_DIV4: begin
        st_d.pre_cnt = st_q.pre_cnt + 2'h1;
        st_d.clk_en = (st_q.pre_cnt == `UMCS_PRESCALE_LAST); // R1
      end
      default: begin
        st_d.pre_cnt = 2'h0;
        st_d.clk_en = 1'b1;
      end
    endcase

    // modem outputs, held inactive in loop-back
    if (loop) begin
      st_d.rts_n = 1'b1;
      st_d.dtr_n = 1'b1;
      st_d.gp_out_n = 1'b1;
      st_d.tx_pin = 1'b1;
      st_d.rx_core = core_tx; // R5
    end else begin
      if (auto_rts_en) begin
        st_d.rts_n = auto_rts_n; // R9
      end else begin
        st_d.rts_n = ~st_q.modem_control_reg[`UMCS_MC_RTS]; // R9
      end
      st_d.dtr_n = ~st_q.modem_control_reg[`UMCS_MC_DTR]; // R10
      st_d.gp_out_n = ~st_q.modem_control_reg[`UMCS_MC_GP_OUT]; // R7
      st_d.tx_pin = core_tx;
      st_d.rx_core = rx_pin_s;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q.modem_control_reg <= `UMCS_MODEM_CONTROL_RST;
      st_q.delta <= 4'h0;
      st_q.rdata <= `UMCS_RDATA_RST;
      st_q.pre_cnt <= 2'h0;
      st_q.clk_en <= 1'b0;
      st_q.rts_n <= 1'b1;
      st_q.dtr_n <= 1'b1;
      st_q.gp_out_n <= 1'b1;
      st_q.tx_pin <= 1'b1;
      st_q.rx_core <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign bus_rdata = st_q.rdata;
  assign rts_n = st_q.rts_n;
  assign dtr_n = st_q.dtr_n;
  assign gp_out_n = st_q.gp_out_n;
  assign tx_pin = st_q.tx_pin;
  assign core_rx = st_q.rx_core;
  assign baud_clk_en = st_q.clk_en;
  assign tcr_tlr_access = st_q.modem_control_reg[`UMCS_MC_TCR_TLR_EN]; // R2
  assign xon_any_en = st_q.modem_control_reg[`UMCS_MC_XON_ANY]; // R3
  assign fifo_rdy_en = st_q.modem_control_reg[`UMCS_MC_FIFO_RDY]; // R8
  assign loopback_en = loop;
  assign modem_irq = modem_irq_en & (|st_q.delta); // R17

endmodule

// *** testbench/umcs_top_checker.sv ***
/*
  Port checker of the modem control and status block.
  Assumes it is bound to umcs_top and sees only its ports.
*/
`timescale 1ns/100ps
`include "umcs_consts.svh"
module umcs_chk #(
  parameter int PRESCALE = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_cs,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [`UMCS_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic enh_write_en,
  input wire logic auto_rts_en,
  input wire logic modem_irq_en,
  input wire logic core_tx,
  input wire logic core_rx,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic gp_out_n,
  input wire logic baud_clk_en,
  input wire logic tcr_tlr_access,
  input wire logic xon_any_en,
  input wire logic fifo_rdy_en,
  input wire logic modem_irq
);
  logic [7:0] sh_q;
  logic [2:0] age_q;
  logic ok;
  logic rd_s;
  assign ok = age_q > 3'h3;
  assign rd_s = bus_cs && bus_rd && bus_addr == `UMCS_MODEM_STATUS_ADDR;
  // ==========================================================
  // shadow of the control register, age since last write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 8'h00;
      age_q <= 3'h0;
    end else if (bus_cs && bus_wr && bus_addr == `UMCS_MODEM_CONTROL_ADDR) begin
      sh_q[4:0] <= bus_wdata[4:0];
      if (enh_write_en) begin
        sh_q[7:5] <= bus_wdata[7:5];
      end
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_div1_rate: assert property (ok && !sh_q[7] |-> baud_clk_en)
    else $error("baud enable missing in divide-by-1");
  a_div4_gap: assert property (ok && sh_q[7] && baud_clk_en
    |=> !baud_clk_en [*3] ##1 baud_clk_en) else $error("divide-by-4 spacing wrong");
  a_tcr_access: assert property (ok |-> tcr_tlr_access == sh_q[6])
    else $error("trigger access enable wrong");
  a_xon_any: assert property (ok |-> xon_any_en == sh_q[5])
    else $error("xon any enable wrong");
  a_ctrl_mask: assert property (bus_cs && bus_rd
    && bus_addr == `UMCS_MODEM_CONTROL_ADDR |=> bus_rdata == $past(sh_q))
    else $error("control read-back wrong");
  a_loop_rx: assert property (ok && sh_q[4] |=> core_rx == $past(core_tx))
    else $error("loop-back receive wrong");
  a_loop_status: assert property (ok && sh_q[4] && rd_s
    |=> bus_rdata[7:4] == {sh_q[3], sh_q[2], sh_q[0], sh_q[1]})
    else $error("loop-back status wrong");
  a_gp_drive: assert property (ok |-> gp_out_n == !(sh_q[3] && !sh_q[4]))
    else $error("general output level wrong");
  a_fifo_rdy: assert property (ok |-> fifo_rdy_en == sh_q[2])
    else $error("fifo ready enable wrong");
  a_rts_drive: assert property (ok && !auto_rts_en
    |-> rts_n == !(sh_q[1] && !sh_q[4])) else $error("request to send level wrong");
  a_dtr_drive: assert property (ok |-> dtr_n == !(sh_q[0] && !sh_q[4]))
    else $error("terminal ready level wrong");
  a_irq_mask: assert property (!modem_irq_en |-> !modem_irq)
    else $error("modem interrupt while disabled");
endmodule
bind umcs_top umcs_chk #(.PRESCALE(PRESCALE)) chk_u (.clk, .rst_n, .bus_cs, .bus_wr,
  .bus_rd, .bus_addr, .bus_wdata, .bus_rdata, .enh_write_en, .auto_rts_en,
  .modem_irq_en, .core_tx, .core_rx, .rts_n, .dtr_n, .gp_out_n, .baud_clk_en,
  .tcr_tlr_access, .xon_any_en, .fifo_rdy_en, .modem_irq);

// *** testbench/umcs_modem.sv ***
/*
  Modem model on the pin side: drives active-low status lines, echoes tx.
  Assumes the bench asks for line states as active-high wishes.
*/
`timescale 1ns/100ps
module umcs_modem (
  input wire logic clk,
  input wire logic [3:0] want,
  input wire logic tx_pin,
  output logic cd_n,
  output logic ri_n,
  output logic dsr_n,
  output logic cts_n,
  output logic rx_pin
);
  always_ff @(posedge clk) begin
    {cd_n, ri_n, dsr_n, cts_n} <= ~want;
    rx_pin <= tx_pin;
  end
endmodule

// *** testbench/testbench.sv ***
/*
  Self-checking bench of umcs_top with a modem model.
  Assumes inputs change on the falling clock edge.
*/
`timescale 1ns/100ps
`include "umcs_consts.svh"
module testbench;
  logic clk, rst_n, bus_cs, bus_wr, bus_rd, enh_write_en, auto_rts_en, auto_rts_n;
  logic modem_irq_en, core_tx, core_rx, rx_pin, tx_pin, cd_n, ri_n, dsr_n, cts_n;
  logic rts_n, dtr_n, gp_out_n, baud_clk_en, tcr_tlr_access, xon_any_en;
  logic fifo_rdy_en, loopback_en, modem_irq;
  logic [2:0] bus_addr;
  logic [3:0] want;
  logic [7:0] bus_wdata, bus_rdata, rd_v, cnt;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  localparam logic [2:0] ca = `UMCS_MODEM_CONTROL_ADDR;
  localparam logic [2:0] sa = `UMCS_MODEM_STATUS_ADDR;
  umcs_top #(.PRESCALE(4)) dut_u (.clk, .rst_n, .bus_cs, .bus_wr, .bus_rd, .bus_addr,
    .bus_wdata, .bus_rdata, .enh_write_en, .auto_rts_en, .auto_rts_n, .modem_irq_en,
    .core_tx, .core_rx, .rx_pin, .tx_pin, .cd_n, .ri_n, .dsr_n, .cts_n, .rts_n, .dtr_n,
    .gp_out_n, .baud_clk_en, .tcr_tlr_access, .xon_any_en, .fifo_rdy_en, .loopback_en,
    .modem_irq);
  umcs_modem modem_u (.clk, .want, .tx_pin, .cd_n, .ri_n, .dsr_n, .cts_n, .rx_pin);
  // ==========================================================
  // clock, timeout, shared tasks
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    {bus_cs, bus_wr, bus_addr, bus_wdata} = {2'b11, a, d};
    @(negedge clk);
    {bus_cs, bus_wr} = 2'b00;
  endtask
  task automatic rd(input logic [2:0] a);
    @(negedge clk);
    {bus_cs, bus_rd, bus_addr} = {2'b11, a};
    @(negedge clk);
    {bus_cs, bus_rd} = 2'b00;
    rd_v = bus_rdata;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(ca);
    chk(rd_v, 8'h00, "control reset");
    chk({5'h0, rts_n, dtr_n, gp_out_n}, 8'h07, "outputs idle");
    core_tx = 1'b0;
    idle(8);
    chk({7'h0, core_rx}, 8'h00, "receive path");
    core_tx = 1'b1;
    $display("t_reset done");
  endtask
  task automatic t_ctrl();
    wr(ca, 8'hef);
    idle(4);
    rd(ca);
    chk(rd_v, 8'h0f, "masked write");
    chk({2'h0, tcr_tlr_access, xon_any_en, fifo_rdy_en, gp_out_n, rts_n, dtr_n},
      8'h08, "outs on");
    enh_write_en = 1'b1;
    wr(ca, 8'he0);
    enh_write_en = 1'b0;
    idle(4);
    rd(ca);
    chk(rd_v, 8'he0, "enabled write");
    chk({2'h0, tcr_tlr_access, xon_any_en, fifo_rdy_en, gp_out_n, rts_n, dtr_n},
      8'h37, "outs off");
    cnt = 8'h00;
    repeat (16) begin
      @(negedge clk);
      cnt = cnt + {7'h0, baud_clk_en};
    end
    chk(cnt, 8'h04, "divide-by-4 pulses");
    $display("t_ctrl done");
  endtask
  task automatic t_auto();
    {auto_rts_en, auto_rts_n} = 2'b10;
    wr(ca, 8'h00);
    idle(4);
    chk({7'h0, rts_n}, 8'h00, "auto low");
    auto_rts_n = 1'b1;
    idle(4);
    chk({7'h0, rts_n}, 8'h01, "auto high");
    auto_rts_en = 1'b0;
    wr(ca, 8'h02);
    idle(4);
    chk({7'h0, rts_n}, 8'h00, "manual low");
    $display("t_auto done");
  endtask
  task automatic t_status();
    modem_irq_en = 1'b1;
    rd(sa);
    want = 4'hf;
    idle(6);
    chk({7'h0, modem_irq}, 8'h01, "irq raised");
    rd(sa);
    chk(rd_v, 8'hfb, "all asserted");
    rd(sa);
    chk(rd_v, 8'hf0, "flags once");
    chk({7'h0, modem_irq}, 8'h00, "irq cleared");
    modem_irq_en = 1'b0;
    want = 4'h0;
    idle(6);
    chk({7'h0, modem_irq}, 8'h00, "irq masked");
    rd(sa);
    chk(rd_v, 8'h0f, "all released");
    wr(sa, 8'hff);
    rd(3'h0);
    chk(rd_v, 8'h00, "unmapped");
    rd(sa);
    chk(rd_v, 8'h00, "status read-only");
    $display("t_status done");
  endtask
  task automatic t_loop();
    wr(ca, 8'h1f);
    idle(4);
    rd(sa);
    chk({3'h0, loopback_en, rts_n, dtr_n, gp_out_n, tx_pin}, 8'h1f, "pins parked");
    core_tx = 1'b0;
    idle(1);
    chk({7'h0, core_rx}, 8'h00, "internal loop");
    core_tx = 1'b1;
    wr(ca, 8'h1a);
    idle(2);
    rd(sa);
    chk(rd_v, 8'h92, "dsr change");
    wr(ca, 8'h1e);
    idle(2);
    rd(sa);
    chk(rd_v, 8'hd4, "ring rise");
    wr(ca, 8'h15);
    idle(2);
    rd(sa);
    chk(rd_v, 8'h6b, "cd and cts change");
    wr(ca, 8'h00);
    $display("t_loop done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, bus_cs, bus_wr, bus_rd, enh_write_en, auto_rts_en, modem_irq_en} = 7'h00;
    {auto_rts_n, core_tx, bus_addr, bus_wdata, want} = {2'b11, 3'h0, 8'h00, 4'h0};
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    idle(6);
    t_reset();
    t_ctrl();
    t_auto();
    t_status();
    t_loop();
    print_verdict();
  end
endmodule
